// ### tb/dual_wiper_i2c_write_port_tb_top.sv
// Purpose: Self-checking bench for the dual wiper write port
// Assumes: Master model paces the bus from the core clock
// Notes:   Wiper codes are checked right after the data byte
`timescale 1ns/1ps
`default_nettype none

module dual_wiper_i2c_write_port_tb_top;
	import dwp_pkg::*;
	logic        core_clk;
	logic        rstn;
	logic        scl;
	logic        sda_m;
	logic        sda_o;
	logic        sda_oe;
	wire logic   sda_w;
	logic [2:0]  straps;
	dwp_wipers_t pot_codes;
	dwp_wipers_t exp;
	int          error_cnt;
	int          samples_checked;
	logic [7:0]  cmds [4] = '{8'h11, 8'h12, 8'h13, 8'h12};
	logic [7:0]  dats [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};

	// Pull-up wins unless either party pulls low
	assign sda_w = sda_oe ? (sda_o & sda_m) : sda_m;

	dwp_target dut (
		.core_clk        (core_clk),
		.rstn            (rstn),
		.scl_i           (scl),
		.sda_i           (sda_w),
		.sda_o           (sda_o),
		.sda_oe          (sda_oe),
		.addr_strap_bit0 (straps[0]),
		.addr_strap_bit1 (straps[1]),
		.addr_strap_bit2 (straps[2]),
		.pot_codes       (pot_codes)
	);

	dwp_master_model m (
		.core_clk (core_clk),
		.sda_w    (sda_w),
		.scl      (scl),
		.sda_m    (sda_m)
	);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] want);
		samples_checked++;
		if (seen !== want) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic test_done();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [6:0] adr, input logic nop,
		input logic [7:0] cmd, input logic [7:0] dat, input logic ack_exp);
		logic ack;
		m.start_cond();
		m.send_byte({adr, nop}, ack);
		check("addr ack", 16'(ack), 16'(ack_exp));
		if (ack) begin
			m.send_byte(cmd, ack);
			check("cmd ack", 16'(ack), 16'h0001);
			m.send_byte(dat, ack);
			check("data ack", 16'(ack), 16'h0001);
			check("codes now", pot_codes, exp);
		end
		m.stop_cond();
		check("codes", pot_codes, exp);
		check("idle", 16'({scl, sda_w, sda_oe}), 16'h0006);
	endtask

	initial begin
		#2_000_000;
		error_cnt++;
		test_done();
	end

	initial begin
		rstn = 1'b0;
		straps = 3'h5;
		error_cnt = 0;
		samples_checked = 0;
		exp = '{8'h80, 8'h80};
		repeat (3) @(posedge core_clk);
		check("reset codes", pot_codes, exp);
		rstn <= 1'b1;
		repeat (10) @(posedge core_clk);
		for (int k = 0; k < 4; k++) begin
			if (cmds[k] != 8'h12)
				exp.code_a = dats[k];
			if (cmds[k] != 8'h11)
				exp.code_b = dats[k];
			wr({4'h5, straps}, 1'b0, cmds[k], dats[k], 1'b1);
		end
		wr({4'h5, straps}, 1'b1, 8'h13, 8'h33, 1'b1);
		wr({4'h4, straps}, 1'b0, 8'h13, 8'h33, 1'b0);
		wr({4'h5, 3'h4}, 1'b0, 8'h13, 8'h33, 1'b0);
		straps <= 3'h2;
		repeat (10) @(posedge core_clk);
		wr({4'h5, 3'h5}, 1'b0, 8'h13, 8'h33, 1'b0);
		exp = '{8'h3C, 8'h3C};
		wr({4'h5, 3'h2}, 1'b0, 8'h13, 8'h3C, 1'b1);
		// Unknown command is acked but must leave both wipers alone
		wr({4'h5, 3'h2}, 1'b0, 8'h10, 8'h77, 1'b1);
		rstn <= 1'b0;
		repeat (3) @(posedge core_clk);
		check("rerun reset", pot_codes, 16'h8080);
		test_done();
	end
endmodule

`default_nettype wire

// ### tb/dwp_master_model.sv
// Purpose: Behavioural two-wire bus master facing the wiper write port
// Assumes: Core clock paces the bus; 3 cycles high, 5 cycles low
// Notes:   Data line is open drain; 1 means released to the pull-up
`timescale 1ns/1ps
`default_nettype none

module dwp_master_model
	import dwp_pkg::*;
(
	input  wire logic core_clk, // Core clock paces the bus
	input  wire logic sda_w,    // Resolved data wire level
	output logic      scl,      // Serial clock, driven by us only
	output logic      sda_m     // Data drive value, 1 = released
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	task automatic start_cond();
		@(posedge core_clk) sda_m <= 1'b0;
		repeat (5) @(posedge core_clk);
		scl <= 1'b0;
	endtask

	// 800 ns period; ack is up one cycle before the rise
	task automatic clk_bit(input logic v, output logic smp);
		logic lo;
		@(posedge core_clk) sda_m <= v;
		repeat (4) @(posedge core_clk);
		scl <= 1'b1;
		@(posedge core_clk) lo = sda_w;
		repeat (2) @(posedge core_clk);
		smp = lo | sda_w;
		scl <= 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic smp;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i], smp);
		end
		clk_bit(1'b1, smp);
		ack = ~smp;
	endtask

	task automatic stop_cond();
		@(posedge core_clk) sda_m <= 1'b0;
		repeat (4) @(posedge core_clk);
		scl <= 1'b1;
		repeat (4) @(posedge core_clk);
		sda_m <= 1'b1;
		repeat (13) @(posedge core_clk);
	endtask
endmodule

`default_nettype wire

// ### verilog/dwp_pkg.sv
// Purpose: Shared constants and types of the dual wiper write port
// Assumes: Core clock at 10 MHz, wire levels resolved outside
// Notes:   Only the write path exists; nothing is ever read back
package dwp_pkg;

	localparam logic [3:0] DWP_ADDR_FIXED  = 4'h5;
	localparam logic [7:0] DWP_WIPER_RESET = 8'h80;
	localparam logic [7:0] DWP_CMD_A       = 8'h11;
	localparam logic [7:0] DWP_CMD_B       = 8'h12;
	localparam logic [7:0] DWP_CMD_AB      = 8'h13;
	localparam logic [3:0] DWP_BIT_ACK     = 4'h8;
	localparam logic [3:0] DWP_BIT_END     = 4'h9;
	localparam logic [3:0] DWP_BIT_ZERO    = 4'h0;
	localparam logic [7:0] DWP_BYTE_ZERO   = 8'h00;

	typedef enum logic [4:0] {
		DWP_ST_IDLE   = 5'h01,
		DWP_ST_ADDR   = 5'h02,
		DWP_ST_CMD    = 5'h04,
		DWP_ST_DATA   = 5'h08,
		DWP_ST_IGNORE = 5'h10
	} dwp_phase_t;

	typedef struct packed {
		logic [7:0] code_a;
		logic [7:0] code_b;
	} dwp_wipers_t;

	typedef struct packed {
		dwp_phase_t  phase;
		logic [3:0]  bit_cnt;
		logic [7:0]  shift;
		logic [7:0]  cmd;
		logic        noop;
		logic        ack;
		logic        scl_prev;
		logic        sda_prev;
		dwp_wipers_t wipers;
	} dwp_state_t;

endpackage

// ### verilog/dwp_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to core_clk
// Notes:   Output moves only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module dwp_sync
	import dwp_pkg::*;
#(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         core_clk, // Core clock
	input  wire logic         rst_n,    // Synchronised reset, active low
	input  wire logic [W-1:0] pin_i,    // Raw asynchronous inputs
	output logic      [W-1:0] flt_o     // Filtered synchronous level
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] held_ff;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff   <= RST_VAL;
			s2_ff   <= RST_VAL;
			s3_ff   <= RST_VAL;
			held_ff <= RST_VAL;
		end else begin
			s1_ff   <= pin_i;
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			held_ff <= flt_o;
		end
	end

	// Per bit: a lone sample of disagreement keeps the old level
	always_comb begin
		for (int i = 0; i < W; i++) begin
			flt_o[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : held_ff[i];
		end
	end

endmodule

`default_nettype wire

// ### verilog/dwp_target.sv
// Purpose: Two-wire write-only target driving two 8-bit wiper codes
// Assumes: Master drives the serial clock; low 5+ cycles, high 3+
// Notes:   Pin delay through the filter is about three core cycles
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Each wiper takes any of 256 positions from its 8-bit code.
// - Separate registers; writing one wiper leaves the other alone.
// - A written code reaches the wiper output at once.
// - Both wiper codes start at midscale 80h after reset.
// - Shift bytes in, decode address and command, deliver data.
// - Data line is input plus pull-low only; clock line is input only.
// - START, address with write bit, command, data, STOP in that order.
// - Idle bus has both lines high; nobody holds them low.
// - One bit per clock pulse, stable while the clock is high.
// - Pull data low through the whole ninth pulse to acknowledge.
// - Eighth address bit low writes, high means no operation.
// - No read path; nothing is ever returned over the bus.
// - Own address is 0101 followed by the three strap levels.
// - Command byte picks wiper A, wiper B or both.
// - Command byte comes first, then the data byte to store.
// - Code 00h is nearest low terminal, FFh nearest high terminal.
module dwp_target
	import dwp_pkg::*;
(
	input  wire logic  core_clk,        // 10 MHz core clock
	input  wire logic  rstn,            // Asynchronous reset, active low
	input  wire logic  scl_i,           // Serial clock level from pin
	input  wire logic  sda_i,           // Serial data level from pin
	output logic       sda_o,           // Serial data drive value
	output logic       sda_oe,          // High while pulling data low
	input  wire logic  addr_strap_bit0, // Address strap, low bit
	input  wire logic  addr_strap_bit1, // Address strap, middle bit
	input  wire logic  addr_strap_bit2, // Address strap, high bit
	output dwp_wipers_t pot_codes       // Wiper codes for pots A and B
);

	function automatic logic [1:0] wiper_sel(input logic [7:0] cmd);
		// Bit 1 selects B, bit 0 selects A; other commands write nothing
		case (cmd)
			DWP_CMD_A:  wiper_sel = 2'h1;
			DWP_CMD_B:  wiper_sel = 2'h2;
			DWP_CMD_AB: wiper_sel = 2'h3;
			default:    wiper_sel = 2'h0;
		endcase
	endfunction

	logic       rst_meta_ff;
	logic       rst_sync_ff;
	logic [4:0] pins_f;
	logic       scl_f;
	logic       sda_f;
	logic [2:0] strap_f;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_ev;
	logic       stop_ev;
	logic       addr_hit;
	logic [1:0] sel;
	dwp_state_t st_ff;
	dwp_state_t nxt_st;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	dwp_sync #(
		.W       (5),
		.RST_VAL (5'h18)
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_sync_ff),
		.pin_i    ({scl_i, sda_i, addr_strap_bit2, addr_strap_bit1,
		            addr_strap_bit0}),
		.flt_o    (pins_f)
	);

	assign scl_f   = pins_f[4];
	assign sda_f   = pins_f[3];
	assign strap_f = pins_f[2:0];

	assign scl_rise = scl_f & ~st_ff.scl_prev;
	assign scl_fall = ~scl_f & st_ff.scl_prev;
	// Data moving while clock stays high is a bus condition, not a bit
	assign start_ev = scl_f & st_ff.scl_prev & st_ff.sda_prev & ~sda_f;
	assign stop_ev  = scl_f & st_ff.scl_prev & ~st_ff.sda_prev & sda_f;
	assign addr_hit = (st_ff.shift[7:1] == {DWP_ADDR_FIXED, strap_f});
	assign sel      = wiper_sel(st_ff.cmd);

	always_comb begin
		nxt_st          = st_ff;
		nxt_st.scl_prev = scl_f;
		nxt_st.sda_prev = sda_f;
		if (start_ev) begin
			// Also a repeated START: always restart on the address
			nxt_st.phase   = DWP_ST_ADDR;
			nxt_st.bit_cnt = DWP_BIT_ZERO;
			nxt_st.ack     = 1'b0;
			nxt_st.noop    = 1'b0;
		end else if (stop_ev) begin
			nxt_st.phase   = DWP_ST_IDLE;
			nxt_st.bit_cnt = DWP_BIT_ZERO;
			nxt_st.ack     = 1'b0;
		end else if (st_ff.phase != DWP_ST_IDLE) begin
			if (scl_rise && st_ff.bit_cnt < DWP_BIT_ACK) begin
				nxt_st.shift = {st_ff.shift[6:0], sda_f};
			end
			if (scl_rise && st_ff.bit_cnt < DWP_BIT_END) begin
				nxt_st.bit_cnt = 4'(st_ff.bit_cnt + 4'h1);
			end
			if (scl_fall && st_ff.bit_cnt == DWP_BIT_ACK) begin
				case (st_ff.phase)
					DWP_ST_ADDR: begin
						if (addr_hit) begin
							nxt_st.ack   = 1'b1;
							nxt_st.noop  = st_ff.shift[0];
							nxt_st.phase = DWP_ST_CMD;
						end else begin
							nxt_st.phase = DWP_ST_IGNORE;
						end
					end
					DWP_ST_CMD: begin
						nxt_st.ack   = 1'b1;
						nxt_st.cmd   = st_ff.shift;
						nxt_st.phase = DWP_ST_DATA;
					end
					DWP_ST_DATA: begin
						// Further bytes rewrite the same wipers
						nxt_st.ack = 1'b1;
						if (!st_ff.noop && sel[0]) begin
							nxt_st.wipers.code_a = st_ff.shift;
						end
						if (!st_ff.noop && sel[1]) begin
							nxt_st.wipers.code_b = st_ff.shift;
						end
					end
					default: begin
						nxt_st.ack = 1'b0;
					end
				endcase
			end else if (scl_fall && st_ff.bit_cnt == DWP_BIT_END) begin
				nxt_st.ack     = 1'b0;
				nxt_st.bit_cnt = DWP_BIT_ZERO;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			st_ff.phase         <= DWP_ST_IDLE;
			st_ff.bit_cnt       <= DWP_BIT_ZERO;
			st_ff.shift         <= DWP_BYTE_ZERO;
			st_ff.cmd           <= DWP_BYTE_ZERO;
			st_ff.noop          <= 1'b0;
			st_ff.ack           <= 1'b0;
			st_ff.scl_prev      <= 1'b1;
			st_ff.sda_prev      <= 1'b1;
			st_ff.wipers.code_a <= DWP_WIPER_RESET;
			st_ff.wipers.code_b <= DWP_WIPER_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Pull-low only and only in an acknowledge slot: no read path exists
	assign sda_o     = 1'b0;
	assign sda_oe    = st_ff.ack;
	// Code maps straight to tap: 00h low end, FFh high end
	assign pot_codes = st_ff.wipers;

	AST_RESET_MID: assert property (@(posedge core_clk)
		$rose(rst_sync_ff) |-> pot_codes.code_a == DWP_WIPER_RESET
			&& pot_codes.code_b == DWP_WIPER_RESET)
		else $error("wiper codes not at midscale after reset");

	AST_WRITE_A_ONLY: assert property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		(st_ff.phase == DWP_ST_DATA && scl_fall && !st_ff.noop
			&& st_ff.bit_cnt == DWP_BIT_ACK && st_ff.cmd == DWP_CMD_A)
		|=> pot_codes.code_a == $past(st_ff.shift)
			&& $stable(pot_codes.code_b))
		else $error("write to wiper A disturbed B or was lost");

	AST_CHANGE_CAUSE: assert property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		$changed(pot_codes) |-> $past(st_ff.phase) == DWP_ST_DATA
			&& $past(scl_fall) && $past(st_ff.bit_cnt) == DWP_BIT_ACK)
		else $error("wiper code changed outside a data byte");

	AST_NOOP_KEEPS: assert property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		st_ff.noop |=> $stable(pot_codes))
		else $error("no-operation transfer changed a wiper");

	AST_DRIVE_ACK_ONLY: assert property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		sda_oe |-> !sda_o && st_ff.bit_cnt >= DWP_BIT_ACK)
		else $error("data line driven outside acknowledge slot");

	AST_ACK_HOLD: assert property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		(sda_oe && scl_rise) |=> sda_oe [*3])
		else $error("acknowledge released during clock high");

	AST_ADDR_NACK: assert property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		(st_ff.phase == DWP_ST_ADDR && scl_fall && !addr_hit
			&& st_ff.bit_cnt == DWP_BIT_ACK)
		|=> !sda_oe && st_ff.phase == DWP_ST_IGNORE)
		else $error("foreign address acknowledged");

	AST_ADDR_ACK: assert property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		(st_ff.phase == DWP_ST_ADDR && scl_fall && addr_hit
			&& st_ff.bit_cnt == DWP_BIT_ACK)
		|=> sda_oe ##1 sda_oe)
		else $error("own address not acknowledged");

	AST_IDLE_FREE: assert property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		st_ff.phase == DWP_ST_IDLE |-> !sda_oe)
		else $error("data line held low while idle");

	AST_STOP_IDLE: assert property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		stop_ev |=> st_ff.phase == DWP_ST_IDLE && st_ff.bit_cnt == 4'h0)
		else $error("stop condition did not free the target");

	COV_WRITE_A: cover property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		$changed(pot_codes.code_a) && $stable(pot_codes.code_b));
	COV_WRITE_BOTH: cover property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		$changed(pot_codes.code_a) && $changed(pot_codes.code_b));
	COV_NACK: cover property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		st_ff.phase == DWP_ST_IGNORE);
	COV_NOOP: cover property (@(posedge core_clk)
		disable iff (!rst_sync_ff)
		st_ff.noop && stop_ev);

endmodule

`default_nettype wire
